// file: rtl/esp_core.sv
// Trigger sync, automatic power-save decision and engine clock selection.
`timescale 1ns/1ns
`default_nettype none
// How it works
// RL1: send sixteen ticks, wait at least sixteen
// RL2: each channel latches incoming triggers until used
// RL3: wait clears latched triggers only on match
// RL4: wait stalls until all selected triggers arrive
// RL5: pin low pulse needs two ticks
// RL6: sent pin pulse lasts exactly three ticks
// RL7: trigger line is active low
// RL8: own pin pulse is never recognised
// RL9: pin send completes before pin wait
// RL10: wait mask 12..7, send mask 6..1
// RL11: top bits 111 mark trigger instruction
// RL12: power save needs enable bit set
// RL13: engines keep running during power save
// RL14: all three channels must qualify together
// RL15: mode decides each channel's power-save condition
// RL16: wait qualifies when idle and long enough
// RL17: ramp qualifies at zero with time left
// RL18: trigger wait and end instruction qualify
// RL19: set-PWM zero qualifies before long wait
// RL20: needed PWM activity launches wake-up
// RL21: clock-source field picks pin, internal, auto
// RL22: detector drops clocks below 15 kHz
// RL23: in-use bit shows detected pin clock
// RL24: trigger pin synchronised before counting
// RL25: trigger pin driven open-drain
module esp_core import esp_pkg::*; #(
   parameter int DET_LIMIT = DET_LIMIT_CYC
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Configuration register and status bit.
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   output logic external_clock_in_use,
   // Slow clock pin.
   input wire logic slow_clock_input,
   // Shared trigger line.
   input wire logic trig_in,
   output logic trig_out,
   output logic trig_oe,
   // Channel engines.
   input wire logic [2:0] ins_start,
   input wire logic [2:0][15:0] ins_word,
   output logic [2:0] ins_done,
   input wire logic [2:0][1:0] ch_mode,
   input wire logic [2:0] pwm_active,
   input wire logic [2:0] pwm_zero,
   input wire logic [2:0][21:0] time_left,
   input wire logic [2:0][21:0] next_wait,
   // Engine timing and power.
   output logic engine_tick,
   output logic power_save,
   output logic wake_up
);
   esp_reg_s s;
   esp_reg_s n;
   logic pin_seen;
   logic [2:0][5:0] setb;
   logic [2:0][5:0] clrb;

   // Power-save threshold in ticks depends on the prescale bit.
   function automatic logic [21:0] ps_limit(input logic pre);
      ps_limit = pre ? 22'(PS_LONG_TICKS) : 22'(PS_SHORT_TICKS);
   endfunction

   // Mask field of a trigger instruction with the unused bits removed.
   function automatic logic [5:0] trig_mask(input logic [15:0] w, input int lsb);
      trig_mask = w[lsb +: 6] & TRIG_VALID;
   endfunction

   // Next-state logic for the whole block.
   always_comb begin
      logic edge_in;
      logic use_pin;
      logic int_tick;
      logic [5:0] wm;
      logic [5:0] sm;
      logic [15:0] w;
      logic q;
      edge_in = 1'b0;
      use_pin = 1'b0;
      int_tick = 1'b0;
      wm = 6'h00;
      sm = 6'h00;
      w = 16'h0000;
      q = 1'b0;
      n = s;
      n.done = 3'h0;
      pin_seen = 1'b0;
      setb = '0;
      clrb = '0;
      if (cfg_wr) begin
         n.cfg = cfg_wdata;
      end
      // RL13 internal oscillator
      // The divider never stops, so engines stay timed during power save.
      int_tick = (s.div_cnt == 12'(INT_DIV_CYC - 1));
      n.div_cnt = int_tick ? 12'h000 : s.div_cnt + 12'h001;
      // RL22 pin clock detector
      // Stuck pins give no edges, so they time out like a slow clock.
      n.clk_prev = slow_clock_input;
      edge_in = slow_clock_input & ~s.clk_prev;
      if (edge_in) begin
         n.det_cnt = 14'h0000;
         n.slow_ok = 1'b1;
      end else if (s.det_cnt == 14'(DET_LIMIT - 1)) begin
         n.slow_ok = 1'b0;
      end else begin
         n.det_cnt = s.det_cnt + 14'h0001;
      end
      // RL23 in-use status
      n.in_use = s.cfg[CFG_DET_BIT] & s.slow_ok;
      // RL21 clock source select
      case (s.cfg[CFG_DET_BIT:CFG_CLK_LSB])
         CLK_SEL_PIN: use_pin = 1'b1;
         CLK_SEL_AUTO: use_pin = s.slow_ok;
         default: use_pin = 1'b0;
      endcase
      n.tick = use_pin ? edge_in : int_tick;
      // RL24 line synchroniser
      n.trig_s1 = trig_in;
      n.trig_s2 = s.trig_s1;
      // RL8 own pulse masked
      // RL5 low-duration filter
      // RL7 low means trigger present
      if (s.drv_on | s.trig_s2) begin
         n.low_cnt = 2'h0;
      end else if (s.tick && s.low_cnt != 2'(PIN_MIN_TICKS)) begin
         n.low_cnt = s.low_cnt + 2'h1;
         pin_seen = (s.low_cnt == 2'(PIN_MIN_TICKS - 1));
      end
      // RL6 three-tick drive
      if (s.drv_on && s.tick) begin
         if (s.drv_cnt == 2'(DRIVE_TICKS - 1)) begin
            n.drv_on = 1'b0;
         end else begin
            n.drv_cnt = s.drv_cnt + 2'h1;
         end
      end
      // Per-channel trigger sequencer.
      for (int c = 0; c < 3; c++) begin
         // RL10 mask fields
         wm = trig_mask(ins_word[c], WAIT_LSB);
         sm = trig_mask(ins_word[c], SEND_LSB);
         case (s.st[c])
            ST_IDLE: begin
               // RL11 trigger decode
               if (ins_start[c] && ins_word[c][15:13] == OP_TRIG) begin
                  n.cnt[c] = 4'h0;
                  n.st[c] = (sm == 6'h00 && wm != 6'h00) ? ST_WAIT : ST_SEND;
               end
            end
            ST_SEND: begin
               if (s.tick) begin
                  // Sends go out on the first tick so the pin pulse is tick-aligned.
                  if (s.cnt[c] == 4'h0) begin
                     for (int d = 0; d < 3; d++) begin
                        setb[d][c] = sm[d];
                     end
                     if (sm[OFFCHIP_SYNC_BIT]) begin
                        n.drv_on = 1'b1;
                        n.drv_cnt = 2'h0;
                     end
                  end
                  // RL1 send length
                  // RL9 send before wait
                  if (s.cnt[c] == INSTR_LAST) begin
                     n.cnt[c] = 4'h0;
                     n.st[c] = (wm == 6'h00) ? ST_IDLE : ST_WAIT;
                     n.done[c] = (wm == 6'h00);
                  end else begin
                     n.cnt[c] = s.cnt[c] + 4'h1;
                  end
               end
            end
            ST_WAIT: begin
               if (s.tick) begin
                  // RL4 stall until all arrive
                  // RL3 clear on match
                  if (s.cnt[c] != INSTR_LAST) begin
                     n.cnt[c] = s.cnt[c] + 4'h1;
                  end else if ((s.lat[c] & wm) == wm) begin
                     clrb[c] = wm;
                     n.st[c] = ST_IDLE;
                     n.done[c] = 1'b1;
                  end
               end
            end
            default: n.st[c] = ST_IDLE;
         endcase
      end
      // RL2 latch until consumed
      // A trigger landing in the clearing cycle survives: set wins.
      for (int c = 0; c < 3; c++) begin
         n.lat[c] = (s.lat[c] & ~clrb[c]) | setb[c] | {pin_seen, 5'h00};
      end
      // RL15 per-mode condition
      for (int c = 0; c < 3; c++) begin
         w = ins_word[c];
         case (ch_mode[c])
            MODE_OFF: q = 1'b1;
            MODE_LOAD: q = 1'b0;
            MODE_DIRECT: q = ~pwm_active[c];
            default: begin
               q = s.qual[c];
               if (s.st[c] == ST_WAIT) begin
                  // RL18 trigger wait
                  q = ~pwm_active[c];
               end else if (w[15:13] == OP_END) begin
                  // RL18 end instruction
                  q = ~pwm_active[c] | w[END_RESET_BIT];
               end else if (!w[15] && w[13:8] != 6'h00) begin
                  if (w[6:0] == 7'h00) begin
                     // RL16 wait look-ahead
                     q = ~pwm_active[c] && time_left[c] > ps_limit(w[PRESCALE_BIT]);
                  end else begin
                     // RL17 ramp look-ahead
                     q = pwm_zero[c] && time_left[c] > ps_limit(w[PRESCALE_BIT]);
                  end
               end else if (!w[15] && w[14:8] == OP_SET_PWM) begin
                  // RL19 set-PWM look-ahead
                  q = w[7:0] == 8'h00 && next_wait[c] >= 22'(PS_SHORT_TICKS);
               end
            end
         endcase
         n.qual[c] = q;
      end
      // RL12 enable gate
      // RL14 all channels agree
      n.ps = s.cfg[CFG_PS_BIT] & (&n.qual);
      // RL20 wake-up launch
      n.wake = s.ps & ~n.ps & s.cfg[CFG_PS_BIT];
   end

   // State register; the line samples reset high so no false trigger appears.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.cfg <= CFG_RESET;
         s.trig_s1 <= 1'b1;
         s.trig_s2 <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // Outputs come straight from the state register, except trig_out, which is tied low.
   assign cfg_rdata = s.cfg;
   assign external_clock_in_use = s.in_use;
   // RL25 open-drain drive
   assign trig_out = 1'b0;
   assign trig_oe = s.drv_on;
   assign engine_tick = s.tick;
   assign power_save = s.ps;
   assign wake_up = s.wake;
   assign ins_done = s.done;

   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence drive_end_seq;
      trig_oe ##1 !trig_oe;
   endsequence

   drive_len_a: assert property ( // RL6
      drive_end_seq |-> $past(s.drv_cnt) == 2'(DRIVE_TICKS - 1) && $past(s.tick))
      else $error("trigger pulse length wrong");
   own_mask_a: assert property ( // RL8
      trig_oe |-> !pin_seen)
      else $error("own trigger pulse recognised");
   pin_len_a: assert property ( // RL5
      pin_seen |-> !s.trig_s2 && $past(!s.trig_s2) && s.low_cnt == 2'(PIN_MIN_TICKS - 1))
      else $error("short low pulse recognised");
   ps_all_a: assert property ( // RL14
      power_save |-> (&s.qual) && $past(s.cfg[CFG_PS_BIT]))
      else $error("power save without all channels");
   clk_use_a: assert property ( // RL23
      external_clock_in_use |-> $past(s.cfg[CFG_DET_BIT]) && $past(s.slow_ok))
      else $error("in-use bit without detected clock");
   wake_start_a: assert property ( // RL20
      wake_up |-> $past(power_save) && !power_save)
      else $error("wake-up outside power save");

   for (genvar c = 0; c < 3; c++) begin : g_chk
      sequence leave_send_seq;
         s.st[c] == ST_SEND ##1 s.st[c] != ST_SEND;
      endsequence
      sequence leave_wait_seq;
         s.st[c] == ST_WAIT ##1 s.st[c] == ST_IDLE;
      endsequence
      send_len_a: assert property ( // RL1
         leave_send_seq |-> $past(s.cnt[c]) == INSTR_LAST && $past(s.tick))
         else $error("send phase not sixteen ticks");
      wait_exit_a: assert property ( // RL4
         leave_wait_seq |-> ins_done[c] && $past(s.cnt[c]) == INSTR_LAST)
         else $error("wait ended early");
      latch_hold_a: assert property ( // RL2
         (s.lat[c] & ~n.lat[c]) != 6'h00 |-> s.st[c] == ST_WAIT && s.tick)
         else $error("latched trigger lost");
   end
endmodule
`default_nettype wire

// file: rtl/esp_pkg.sv
// Constants and state types for the trigger, power-save and clock-select logic.
package esp_pkg;
   // Clock rates.
   localparam int CLK_HZ = 125_000_000;
   localparam int SLOW_HZ = 32_768;
   localparam int INT_DIV_CYC = (CLK_HZ + SLOW_HZ / 2) / SLOW_HZ;
   localparam int DET_MIN_HZ = 15_000;
   localparam int DET_LIMIT_CYC = CLK_HZ / DET_MIN_HZ;
   // Engine tick counts.
   localparam int INSTR_TICKS = 16;
   localparam logic [3:0] INSTR_LAST = 4'(INSTR_TICKS - 1);
   localparam int PIN_MIN_TICKS = 2;
   localparam int DRIVE_TICKS = 3;
   localparam int PS_SHORT_MS = 50;
   localparam int PS_LONG_MS = 80;
   localparam int PS_SHORT_TICKS = PS_SHORT_MS * SLOW_HZ / 1000;
   localparam int PS_LONG_TICKS = PS_LONG_MS * SLOW_HZ / 1000;
   // Register map and fields.
   localparam logic [7:0] CFG_ADDR = 8'h08;
   localparam logic [7:0] STATUS_ADDR = 8'h0c;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam int CFG_PS_BIT = 5;
   localparam int CFG_DET_BIT = 1;
   localparam int CFG_CLK_LSB = 0;
   localparam logic [1:0] CLK_SEL_PIN = 2'h0;
   localparam logic [1:0] CLK_SEL_AUTO = 2'h2;
   // Channel operation modes.
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_LOAD = 2'h1;
   localparam logic [1:0] MODE_DIRECT = 2'h3;
   // Instruction fields.
   localparam logic [2:0] OP_TRIG = 3'h7;
   localparam logic [2:0] OP_END = 3'h6;
   localparam logic [6:0] OP_SET_PWM = 7'h40;
   localparam int WAIT_LSB = 7;
   localparam int SEND_LSB = 1;
   localparam int PRESCALE_BIT = 14;
   localparam int END_RESET_BIT = 11;
   localparam int OFFCHIP_SYNC_BIT = 5;
   localparam logic [5:0] TRIG_VALID = 6'h27;
   typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} esp_state_e;
   typedef struct packed {
      logic [7:0] cfg;
      logic [11:0] div_cnt;
      logic clk_prev;
      logic [13:0] det_cnt;
      logic slow_ok;
      logic in_use;
      logic tick;
      logic trig_s1;
      logic trig_s2;
      logic [1:0] low_cnt;
      logic drv_on;
      logic [1:0] drv_cnt;
      esp_state_e [2:0] st;
      logic [2:0][3:0] cnt;
      logic [2:0][5:0] lat;
      logic [2:0] qual;
      logic [2:0] done;
      logic ps;
      logic wake;
   } esp_reg_s;
endpackage

// file: test/esp_peer.sv
// Neighbouring controller that shares the slow clock and the trigger line.
`timescale 1ns/1ns
`default_nettype none
module esp_peer #(
   parameter int HALF = 8
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Bench commands.
   input wire logic run,
   input wire logic pulse_go,
   input wire logic [1:0] pulse_len,
   // Shared pins.
   output logic slow_clock_input,
   output logic pull_low
);
   int div_ff;
   logic [1:0] left_ff;
   // Stopping the clock leaves the pin stuck, as a dead neighbour would.
   // whole-period low pulse
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         div_ff <= 0;
         slow_clock_input <= 1'b0;
         left_ff <= 2'h0;
         pull_low <= 1'b0;
      end else if (run) begin
         div_ff <= (div_ff == HALF - 1) ? 0 : div_ff + 1;
         if (pulse_go) begin
            left_ff <= pulse_len;
         end
         if (div_ff == HALF - 1) begin
            slow_clock_input <= !slow_clock_input;
            if (!slow_clock_input) begin
               pull_low <= (left_ff != 2'h0);
               if (!pulse_go && left_ff != 2'h0) begin
                  left_ff <= left_ff - 2'h1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the trigger, power-save and clock-select block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int PER = 16;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic cfg_wr = 1'b0;
   logic [7:0] cfg_wdata = 8'h00;
   logic [7:0] cfg_rdata;
   logic in_use, trig_out, trig_oe, engine_tick, power_save, wake_up, slow, pull_low;
   logic [2:0] ins_start = 3'h0;
   logic [2:0][15:0] ins_word = '0;
   logic [2:0] ins_done;
   logic [2:0][1:0] ch_mode = {3{2'h1}};
   logic [2:0] pwm_active = 3'h0;
   logic [2:0] pwm_zero = 3'h7;
   logic [2:0][21:0] time_left = '0;
   logic [2:0][21:0] next_wait = '0;
   logic run = 1'b1;
   logic pulse_go = 1'b0;
   logic [1:0] pulse_len = 2'h0;
   int fails = 0;
   int compares = 0;
   int cyc = 0;
   int ticks = 0;
   int oe_cyc = 0;
   int wakes = 0;
   int dn[3] = '{0, 0, 0};
   // Open-drain line with a pull-up: low while either party pulls it.
   wire trig_line = (trig_oe ? trig_out : 1'b1) & !pull_low;

   esp_core #(.DET_LIMIT(64)) i_dut (.clock(clock), .reset_n(reset_n), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .external_clock_in_use(in_use),
      .slow_clock_input(slow), .trig_in(trig_line), .trig_out(trig_out), .trig_oe(trig_oe),
      .ins_start(ins_start), .ins_word(ins_word), .ins_done(ins_done), .ch_mode(ch_mode),
      .pwm_active(pwm_active), .pwm_zero(pwm_zero), .time_left(time_left), .next_wait(next_wait),
      .engine_tick(engine_tick), .power_save(power_save), .wake_up(wake_up));
   esp_peer #(.HALF(PER / 2)) i_peer (.clock(clock), .reset_n(reset_n), .run(run),
      .pulse_go(pulse_go), .pulse_len(pulse_len), .slow_clock_input(slow), .pull_low(pull_low));

   always #4 clock = ~clock;

   // Event counters; one-cycle pulses are never missed by polling this way.
   always @(posedge clock) begin
      cyc++;
      ticks += engine_tick;
      oe_cyc += trig_oe;
      wakes += wake_up;
      for (int c = 0; c < 3; c++) begin
         dn[c] += ins_done[c];
      end
      if (cyc == 20000) begin
         fails++;
         end_of_test();
      end
   end

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Samples one step after the edge so that registered outputs have settled.
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic write_cfg(input logic [7:0] v);
      @(posedge clock);
      cfg_wr <= 1'b1;
      cfg_wdata <= v;
      @(posedge clock);
      cfg_wr <= 1'b0;
      step(1);
      check(cfg_rdata, v);
   endtask

   // The word is set one edge early so it is stable when the start is taken.
   task automatic start(input int c, input logic [15:0] w, output int t0);
      @(posedge clock);
      ins_word[c] <= w;
      @(posedge clock);
      ins_start[c] <= 1'b1;
      @(posedge clock);
      ins_start[c] <= 1'b0;
      #1;
      t0 = ticks;
   endtask

   task automatic wait_for(input int c, input int d0);
      for (int i = 0; i < 700 && dn[c] == d0; i++) step(1);
   endtask

   task automatic pulse(input logic [1:0] n);
      @(posedge clock);
      pulse_go <= 1'b1;
      pulse_len <= n;
      @(posedge clock);
      pulse_go <= 1'b0;
   endtask

   task automatic ps_is(input logic exp);
      step(4);
      check(power_save, exp);
   endtask

   initial begin
      int t0, d0, d1, o0, w0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      step(1);
      check({cfg_rdata, power_save, trig_oe, ins_done}, 0);
      // Red sends to green, green consumes it, then green stalls for another.
      d0 = dn[0];
      start(0, 16'he004, t0);
      wait_for(0, d0);
      check(ticks - t0, 16);
      d0 = dn[1];
      start(1, 16'he080, t0);
      wait_for(1, d0);
      check(ticks - t0, 16);
      d0 = dn[1];
      d1 = dn[0];
      start(1, 16'he080, t0);
      step(40 * PER);
      check(dn[1] - d0, 0);
      start(0, 16'he004, t0);
      wait_for(1, d0);
      check(dn[1] - d0, 1);
      wait_for(0, d1);
      // Red sends on the line then waits on it; blue waits on the line too.
      o0 = oe_cyc;
      d0 = dn[0];
      d1 = dn[2];
      start(2, 16'hf000, t0);
      start(0, 16'hf040, t0);
      step(40 * PER);
      check(oe_cyc - o0, 3 * PER);
      check(trig_out, 0);
      check(dn[0] - d0 + dn[2] - d1, 0);
      pulse(2'h1);
      step(10 * PER);
      check(dn[0] - d0 + dn[2] - d1, 0);
      pulse(2'h2);
      step(10 * PER);
      check(dn[0] - d0, 1);
      check(dn[2] - d1, 1);
      // A non-trigger word is not taken, so it never reports done.
      d0 = dn[0];
      start(0, 16'hc000, t0);
      step(20 * PER);
      check(dn[0] - d0, 0);
      // Every mode with an end-with-reset word; load mode alone blocks.
      write_cfg(8'h20);
      w0 = wakes;
      @(posedge clock);
      ins_word <= {3{16'hc800}};
      for (int m = 0; m < 4; m++) begin
         @(posedge clock);
         ch_mode <= {3{m[1:0]}};
         step(4);
         check(power_save, m != 1);
      end
      check(wakes - w0, 1);
      t0 = ticks;
      step(4 * PER);
      check(ticks - t0, 4);
      @(posedge clock);
      pwm_active <= 3'h4;
      ps_is(1'b0);
      @(posedge clock);
      pwm_active <= 3'h0;
      ps_is(1'b1);
      // Wait word at both thresholds, without and with prescale.
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         ch_mode <= {3{2'h2}};
         ins_word <= {3{i[1] ? 16'h4100 : 16'h0100}};
         time_left <= {3{(i[1] ? 22'd2621 : 22'd1638) + 22'(i[0])}};
         step(4);
         check(power_save, i[0]);
      end
      // Ramp and set-PWM look-ahead, each on both sides of its condition.
      @(posedge clock);
      ins_word <= {3{16'h0101}};
      time_left <= {3{22'd1639}};
      pwm_zero <= 3'h6;
      ps_is(1'b0);
      @(posedge clock);
      pwm_zero <= 3'h7;
      ps_is(1'b1);
      @(posedge clock);
      ins_word <= {3{16'h4000}};
      next_wait <= {3{22'd1637}};
      ps_is(1'b0);
      @(posedge clock);
      next_wait <= {3{22'd1638}};
      ps_is(1'b1);
      @(posedge clock);
      ins_word[1] <= 16'h4001;
      ps_is(1'b0);
      write_cfg(8'h00);
      ps_is(1'b0);
      // Automatic selection with detection, then a stuck pin clock.
      write_cfg(8'h02);
      step(8);
      check(in_use, 1);
      @(posedge clock);
      run <= 1'b0;
      step(100);
      check(in_use, 0);
      @(posedge clock);
      run <= 1'b1;
      step(2 * PER + 4);
      check(in_use, 1);
      write_cfg(8'h01);
      step(2);
      check(in_use, 0);
      end_of_test();
   end
endmodule
`default_nettype wire
